// file: hw/page_walk_attr_control.sv
// module: walk attribute control registers, system register port and walk attribute output
`timescale 1ns/1ps

// Functional notes
// - alias usable only with host extension enabled
// - alias with host extension off is undefined
// - el1 register traps also govern alias; the code applies only the el3 trap to it, at el2
// - hyp register 64 bits, reserved bits zero
// - hyp upper base: bit5 enables, bit13 attribute1
// - hyp upper base: bit4 enables, bit12 attribute0
// - hyp lower base: bit1 enables, bit9 attribute1
// - hyp lower base: bit0 enables, bit8 attribute0
// - hyp register only for el2 regime walks
// - hyp register at op1 4, op2 0
// - hyp register accessible at el2 and el3
// - mon register 64 bits, el3 regime walks
// - mon: bits1:0 enable, bits9:8 values
// - mon register at op1 6, op2 0
// - mon register accessible only at el3
// - stage-2 register for non-secure stage-2 walks
// - stage-2 register same layout as mon
// - stage-2 register at op1 4, op2 1
// - stage-2 register accessible at el2 and el3
// - el1 register op1 0, alias op1 5
module page_walk_attr_control (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic sysreg_req_i,
	input wire logic sysreg_write_i,
	input wire logic [1:0] sysreg_op0_i,
	input wire logic [2:0] sysreg_op1_i,
	input wire logic [3:0] sysreg_crn_i,
	input wire logic [3:0] sysreg_crm_i,
	input wire logic [2:0] sysreg_op2_i,
	input wire logic [63:0] sysreg_wdata_i,
	input wire logic [1:0] cur_el_i,
	input wire logic host_extension_enable_i,
	input wire logic el1_trap_to_el2_i,
	input wire logic el1_trap_to_el3_i,
	input wire logic walk_req_i,
	input wire logic [1:0] walk_regime_i,
	input wire logic walk_upper_base_i,
	input wire logic walk_secure_i,
	input wire logic stage2_enable_i,
	output logic sysreg_ack_o,
	output logic [63:0] sysreg_rdata_o,
	output logic sysreg_undef_o,
	output logic sysreg_trap_el2_o,
	output logic sysreg_trap_el3_o,
	output logic walk_ack_o,
	output logic [1:0] page_hw_attribute_o
);

	////////////////////////////////////////////////////////////////////////////////
	// register state

	logic [63:0] el1_walk_attr_ctrl_ff;
	logic [63:0] hyp_walk_attr_ctrl_ff;
	logic [63:0] mon_walk_attr_ctrl_ff;
	logic [63:0] stage2_walk_attr_ctrl_ff;

	logic sysreg_ack_ff;
	logic [63:0] sysreg_rdata_ff;
	logic sysreg_undef_ff;
	logic sysreg_trap_el2_ff;
	logic sysreg_trap_el3_ff;
	logic walk_ack_ff;
	logic [1:0] page_hw_attribute_ff;

	////////////////////////////////////////////////////////////////////////////////
	// access decode

	walk_attr_pkg::reg_sel_t target;
	logic enc_common;
	logic is_el1_enc;
	logic is_alias_enc;
	logic is_hyp_enc;
	logic is_mon_enc;
	logic is_s2_enc;
	logic el2_or_el3;
	logic nxt_undef;
	logic nxt_trap_el2;
	logic nxt_trap_el3;
	logic access_ok;
	logic refused;
	logic [63:0] nxt_rdata;

	assign enc_common = (sysreg_op0_i == walk_attr_pkg::ENC_OP0)
		&& (sysreg_crn_i == walk_attr_pkg::ENC_CRN)
		&& (sysreg_crm_i == walk_attr_pkg::ENC_CRM);

	// el1 register and its alias
	assign is_el1_enc = enc_common && (sysreg_op1_i == walk_attr_pkg::OP1_EL1)
		&& (sysreg_op2_i == walk_attr_pkg::OP2_BASE);
	assign is_alias_enc = enc_common && (sysreg_op1_i == walk_attr_pkg::OP1_ALIAS)
		&& (sysreg_op2_i == walk_attr_pkg::OP2_BASE);
	assign is_hyp_enc = enc_common && (sysreg_op1_i == walk_attr_pkg::OP1_HYP)
		&& (sysreg_op2_i == walk_attr_pkg::OP2_BASE);
	assign is_mon_enc = enc_common && (sysreg_op1_i == walk_attr_pkg::OP1_MON)
		&& (sysreg_op2_i == walk_attr_pkg::OP2_BASE);
	assign is_s2_enc = enc_common && (sysreg_op1_i == walk_attr_pkg::OP1_HYP)
		&& (sysreg_op2_i == walk_attr_pkg::OP2_STAGE2);

	assign el2_or_el3 = (cur_el_i == walk_attr_pkg::EL2) || (cur_el_i == walk_attr_pkg::EL3);

	always_comb begin
		target = walk_attr_pkg::SEL_NONE;
		nxt_undef = 1'b0;
		nxt_trap_el2 = 1'b0;
		nxt_trap_el3 = 1'b0;
		if (is_el1_enc) begin
			// at el2 with host extension the el1 encoding reaches the hyp register
			if ((cur_el_i == walk_attr_pkg::EL2) && host_extension_enable_i) begin
				target = walk_attr_pkg::SEL_HYP;
			end else begin
				target = walk_attr_pkg::SEL_EL1;
			end
			if (cur_el_i == walk_attr_pkg::EL0) begin
				nxt_undef = 1'b1;
			end else if (el1_trap_to_el2_i && (cur_el_i == walk_attr_pkg::EL1)) begin
				nxt_trap_el2 = 1'b1;
			end else if (el1_trap_to_el3_i && (cur_el_i != walk_attr_pkg::EL3)) begin
				nxt_trap_el3 = 1'b1;
			end
		end else if (is_alias_enc) begin
			target = walk_attr_pkg::SEL_EL1;
			if (!host_extension_enable_i || !el2_or_el3) begin
				nxt_undef = 1'b1;
			end else if (el1_trap_to_el3_i && (cur_el_i == walk_attr_pkg::EL2)) begin
				nxt_trap_el3 = 1'b1;
			end
		end else if (is_hyp_enc) begin
			target = walk_attr_pkg::SEL_HYP;
			nxt_undef = !el2_or_el3;
		end else if (is_mon_enc) begin
			target = walk_attr_pkg::SEL_MON;
			nxt_undef = (cur_el_i != walk_attr_pkg::EL3);
		end else if (is_s2_enc) begin
			target = walk_attr_pkg::SEL_S2;
			nxt_undef = !el2_or_el3;
		end
	end

	// undef outranks both traps in the decode above
	assign refused = nxt_undef || nxt_trap_el2 || nxt_trap_el3;
	assign access_ok = sysreg_req_i && (target != walk_attr_pkg::SEL_NONE) && !refused;

	// reserved bits read as zero since only writable bits are ever stored
	always_comb begin
		unique case (target)
			walk_attr_pkg::SEL_NONE: nxt_rdata = walk_attr_pkg::REG_RESET;
			walk_attr_pkg::SEL_EL1: nxt_rdata = el1_walk_attr_ctrl_ff;
			walk_attr_pkg::SEL_HYP: nxt_rdata = hyp_walk_attr_ctrl_ff;
			walk_attr_pkg::SEL_MON: nxt_rdata = mon_walk_attr_ctrl_ff;
			walk_attr_pkg::SEL_S2: nxt_rdata = stage2_walk_attr_ctrl_ff;
			default: nxt_rdata = walk_attr_pkg::REG_RESET;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes

	// refused accesses never reach a register
	logic wr_el1;
	logic wr_hyp;
	logic wr_mon;
	logic wr_s2;

	assign wr_el1 = access_ok && sysreg_write_i && (target == walk_attr_pkg::SEL_EL1);
	assign wr_hyp = access_ok && sysreg_write_i && (target == walk_attr_pkg::SEL_HYP);
	assign wr_mon = access_ok && sysreg_write_i && (target == walk_attr_pkg::SEL_MON);
	assign wr_s2 = access_ok && sysreg_write_i && (target == walk_attr_pkg::SEL_S2);

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			el1_walk_attr_ctrl_ff <= walk_attr_pkg::REG_RESET;
		end else if (wr_el1) begin
			el1_walk_attr_ctrl_ff <= sysreg_wdata_i & walk_attr_pkg::TWO_BASE_MASK;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			hyp_walk_attr_ctrl_ff <= walk_attr_pkg::REG_RESET;
		end else if (wr_hyp) begin
			hyp_walk_attr_ctrl_ff <= sysreg_wdata_i & walk_attr_pkg::TWO_BASE_MASK;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			mon_walk_attr_ctrl_ff <= walk_attr_pkg::REG_RESET;
		end else if (wr_mon) begin
			mon_walk_attr_ctrl_ff <= sysreg_wdata_i & walk_attr_pkg::ONE_BASE_MASK;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			stage2_walk_attr_ctrl_ff <= walk_attr_pkg::REG_RESET;
		end else if (wr_s2) begin
			stage2_walk_attr_ctrl_ff <= sysreg_wdata_i & walk_attr_pkg::ONE_BASE_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// access response

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sysreg_ack_ff <= 1'b0;
		end else begin
			sysreg_ack_ff <= sysreg_req_i && (target != walk_attr_pkg::SEL_NONE);
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sysreg_undef_ff <= 1'b0;
		end else begin
			sysreg_undef_ff <= sysreg_req_i && nxt_undef;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sysreg_trap_el2_ff <= 1'b0;
		end else begin
			sysreg_trap_el2_ff <= sysreg_req_i && nxt_trap_el2;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sysreg_trap_el3_ff <= 1'b0;
		end else begin
			sysreg_trap_el3_ff <= sysreg_req_i && nxt_trap_el3;
		end
	end

	// refused and foreign requests clear the read data so nothing stale leaks
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sysreg_rdata_ff <= walk_attr_pkg::REG_RESET;
		end else if (access_ok && !sysreg_write_i) begin
			sysreg_rdata_ff <= nxt_rdata;
		end else if (sysreg_req_i) begin
			sysreg_rdata_ff <= walk_attr_pkg::REG_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// attribute selection per base

	walk_attr_if el1_lower ();
	walk_attr_if el1_upper ();
	walk_attr_if hyp_lower ();
	walk_attr_if hyp_upper ();
	walk_attr_if mon_pair ();
	walk_attr_if s2_pair ();

	assign el1_lower.enable = el1_walk_attr_ctrl_ff[walk_attr_pkg::LOWER_EN_LSB +: 2];
	assign el1_lower.value = el1_walk_attr_ctrl_ff[walk_attr_pkg::LOWER_VAL_LSB +: 2];
	assign el1_upper.enable = el1_walk_attr_ctrl_ff[walk_attr_pkg::UPPER_EN_LSB +: 2];
	assign el1_upper.value = el1_walk_attr_ctrl_ff[walk_attr_pkg::UPPER_VAL_LSB +: 2];
	// bits 1:0 enable, bits 9:8 value, bit 8 taken as attribute 0
	assign hyp_lower.enable = hyp_walk_attr_ctrl_ff[walk_attr_pkg::LOWER_EN_LSB +: 2];
	assign hyp_lower.value = hyp_walk_attr_ctrl_ff[walk_attr_pkg::LOWER_VAL_LSB +: 2];
	// bits 5:4 enable, bits 13:12 value
	assign hyp_upper.enable = hyp_walk_attr_ctrl_ff[walk_attr_pkg::UPPER_EN_LSB +: 2];
	assign hyp_upper.value = hyp_walk_attr_ctrl_ff[walk_attr_pkg::UPPER_VAL_LSB +: 2];
	assign mon_pair.enable = mon_walk_attr_ctrl_ff[walk_attr_pkg::EN_LSB +: 2];
	assign mon_pair.value = mon_walk_attr_ctrl_ff[walk_attr_pkg::VAL_LSB +: 2];
	assign s2_pair.enable = stage2_walk_attr_ctrl_ff[walk_attr_pkg::EN_LSB +: 2];
	assign s2_pair.value = stage2_walk_attr_ctrl_ff[walk_attr_pkg::VAL_LSB +: 2];

	walk_attr_sel u_el1_lower (.pair(el1_lower.sel));
	walk_attr_sel u_el1_upper (.pair(el1_upper.sel));
	walk_attr_sel u_hyp_lower (.pair(hyp_lower.sel));
	walk_attr_sel u_hyp_upper (.pair(hyp_upper.sel));
	walk_attr_sel u_mon (.pair(mon_pair.sel));
	walk_attr_sel u_s2 (.pair(s2_pair.sel));

	////////////////////////////////////////////////////////////////////////////////
	// walk attribute output

	walk_attr_pkg::walk_regime_t regime;
	logic [1:0] nxt_attr;

	assign regime = walk_attr_pkg::walk_regime_t'(walk_regime_i);

	always_comb begin
		unique case (regime)
			walk_attr_pkg::REGIME_EL1: begin
				nxt_attr = walk_upper_base_i ? el1_upper.attr : el1_lower.attr;
			end
			walk_attr_pkg::REGIME_EL1_S2: begin
				if (stage2_enable_i && !walk_secure_i) begin
					nxt_attr = s2_pair.attr;
				end else begin
					nxt_attr = walk_attr_pkg::ATTR_RESET;
				end
			end
			walk_attr_pkg::REGIME_EL2: begin
				nxt_attr = walk_upper_base_i ? hyp_upper.attr : hyp_lower.attr;
			end
			walk_attr_pkg::REGIME_EL3: begin
				nxt_attr = mon_pair.attr;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			walk_ack_ff <= 1'b0;
		end else begin
			walk_ack_ff <= walk_req_i;
		end
	end

	// attribute holds between walks so a slow walker still sees it
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			page_hw_attribute_ff <= walk_attr_pkg::ATTR_RESET;
		end else if (walk_req_i) begin
			page_hw_attribute_ff <= nxt_attr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign sysreg_ack_o = sysreg_ack_ff;
	assign sysreg_rdata_o = sysreg_rdata_ff;
	assign sysreg_undef_o = sysreg_undef_ff;
	assign sysreg_trap_el2_o = sysreg_trap_el2_ff;
	assign sysreg_trap_el3_o = sysreg_trap_el3_ff;
	assign walk_ack_o = walk_ack_ff;
	assign page_hw_attribute_o = page_hw_attribute_ff;

endmodule

// file: hw/walk_attr_if.sv
// interface: enable and value pair of one walk base and the resulting attribute bits
`timescale 1ns/1ps
interface walk_attr_if;
	logic [walk_attr_pkg::ATTR_W-1:0] enable;
	logic [walk_attr_pkg::ATTR_W-1:0] value;
	logic [walk_attr_pkg::ATTR_W-1:0] attr;

	modport sel (
		input enable,
		input value,
		output attr
	);

	modport ctrl (
		output enable,
		output value,
		input attr
	);
endinterface

// file: hw/walk_attr_pkg.sv
// package: encodings, field positions, masks and codes of the walk attribute registers
package walk_attr_pkg;

	localparam int unsigned REG_W = 64;
	localparam int unsigned ATTR_W = 2;

	// system register encoding fields
	localparam logic [1:0] ENC_OP0 = 2'h3;
	localparam logic [3:0] ENC_CRN = 4'hf;
	localparam logic [3:0] ENC_CRM = 4'h7;
	localparam logic [2:0] OP1_EL1 = 3'h0;
	localparam logic [2:0] OP1_HYP = 3'h4;
	localparam logic [2:0] OP1_ALIAS = 3'h5;
	localparam logic [2:0] OP1_MON = 3'h6;
	localparam logic [2:0] OP2_BASE = 3'h0;
	localparam logic [2:0] OP2_STAGE2 = 3'h1;

	// exception levels
	localparam logic [1:0] EL0 = 2'h0;
	localparam logic [1:0] EL1 = 2'h1;
	localparam logic [1:0] EL2 = 2'h2;
	localparam logic [1:0] EL3 = 2'h3;

	// two-base layout (el1 and hyp registers)
	localparam int unsigned LOWER_EN_LSB = 0;
	localparam int unsigned UPPER_EN_LSB = 4;
	localparam int unsigned LOWER_VAL_LSB = 8;
	localparam int unsigned UPPER_VAL_LSB = 12;

	// single-base layout (mon and stage-2 registers)
	localparam int unsigned EN_LSB = 0;
	localparam int unsigned VAL_LSB = 8;

	// writable bits; everything else reads as zero
	localparam logic [63:0] TWO_BASE_MASK = 64'h0000_0000_0000_3333;
	localparam logic [63:0] ONE_BASE_MASK = 64'h0000_0000_0000_0303;
	localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
	localparam logic [1:0] ATTR_RESET = 2'h0;

	typedef enum logic [1:0] {
		REGIME_EL1 = 2'b00,
		REGIME_EL1_S2 = 2'b01,
		REGIME_EL2 = 2'b10,
		REGIME_EL3 = 2'b11
	} walk_regime_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_EL1 = 3'b001,
		SEL_HYP = 3'b010,
		SEL_MON = 3'b011,
		SEL_S2 = 3'b100
	} reg_sel_t;

endpackage

// file: hw/walk_attr_sel.sv
// module: gates attribute value bits with their enables, a clear enable gives zero
`timescale 1ns/1ps
module walk_attr_sel (
	walk_attr_if.sel pair
);
	genvar g;
	generate
		for (g = 0; g < walk_attr_pkg::ATTR_W; g++) begin : g_bit
			assign pair.attr[g] = pair.enable[g] & pair.value[g];
		end
	endgenerate
endmodule

// file: verif/page_walk_attr_control_assertions.sv
// checker: port-level properties of the walk attribute control block
`timescale 1ns/1ps
module page_walk_attr_control_assertions (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic sysreg_req_i,
	input wire logic sysreg_write_i,
	input wire logic [1:0] sysreg_op0_i,
	input wire logic [2:0] sysreg_op1_i,
	input wire logic [3:0] sysreg_crn_i,
	input wire logic [3:0] sysreg_crm_i,
	input wire logic [2:0] sysreg_op2_i,
	input wire logic [1:0] cur_el_i,
	input wire logic host_extension_enable_i,
	input wire logic el1_trap_to_el2_i,
	input wire logic walk_req_i,
	input wire logic [1:0] walk_regime_i,
	input wire logic stage2_enable_i,
	input wire logic sysreg_ack_o,
	input wire logic [63:0] sysreg_rdata_o,
	input wire logic sysreg_undef_o,
	input wire logic sysreg_trap_el2_o,
	input wire logic sysreg_trap_el3_o,
	input wire logic walk_ack_o,
	input wire logic [1:0] page_hw_attribute_o
);
	logic hit;
	logic rq;
	logic rq0;
	assign hit = sysreg_op0_i == 2'h3 && sysreg_crn_i == 4'hf && sysreg_crm_i == 4'h7;
	assign rq = sysreg_req_i && hit;
	assign rq0 = rq && sysreg_op2_i == 3'h0;
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	//////////////////////////////////////////////////////////////////////////
	a_mon_low_el: assert property (rq0 && sysreg_op1_i == 3'h6 && cur_el_i != 2'h3
		|=> sysreg_ack_o && sysreg_undef_o)
		else $error("mon access below el3 not undefined");
	a_hyp_low_el: assert property (rq && sysreg_op1_i == 3'h4 && sysreg_op2_i < 3'h2
		&& cur_el_i < 2'h2 |=> sysreg_undef_o)
		else $error("hyp or stage2 access below el2 not undefined");
	a_alias_off: assert property (rq0 && sysreg_op1_i == 3'h5 && !host_extension_enable_i
		|=> sysreg_undef_o)
		else $error("alias access with extension off not undefined");
	a_el1_trap: assert property (rq0 && sysreg_op1_i == 3'h0 && cur_el_i == 2'h1
		&& el1_trap_to_el2_i |=> sysreg_trap_el2_o)
		else $error("el1 register trap to el2 missing");
	a_foreign_quiet: assert property (sysreg_req_i && !hit |=> !sysreg_ack_o)
		else $error("ack for foreign encoding");
	a_refused_zero: assert property (sysreg_req_i && !sysreg_write_i
		##1 (sysreg_undef_o || sysreg_trap_el2_o || sysreg_trap_el3_o)
		|-> sysreg_rdata_o == 64'h0)
		else $error("refused read returned data");
	a_hyp_reserved: assert property (sysreg_ack_o |-> sysreg_rdata_o[63:14] == 50'h0)
		else $error("reserved high bits read nonzero");
	a_mon_reserved: assert property (rq && sysreg_op1_i == 3'h6 && !sysreg_write_i
		|=> sysreg_rdata_o[63:10] == 54'h0 && sysreg_rdata_o[7:2] == 6'h0)
		else $error("mon reserved bits read nonzero");
	a_stage2_off: assert property (walk_req_i && walk_regime_i == 2'h1 && !stage2_enable_i
		|=> walk_ack_o && page_hw_attribute_o == 2'h0)
		else $error("stage2 walk attributes while stage2 off");
	a_reset_clear: assert property ($fell(sys_rst_i)
		|-> page_hw_attribute_o == 2'h0 && !walk_ack_o && !sysreg_ack_o)
		else $error("outputs not clear after reset");
	c_undef: cover property (sysreg_undef_o);
	c_trap3: cover property (sysreg_trap_el3_o);
	c_attr_both: cover property (walk_ack_o && page_hw_attribute_o == 2'h3);
endmodule
bind page_walk_attr_control page_walk_attr_control_assertions chk (.clock_i, .sys_rst_i,
	.sysreg_req_i, .sysreg_write_i, .sysreg_op0_i, .sysreg_op1_i, .sysreg_crn_i, .sysreg_crm_i,
	.sysreg_op2_i, .cur_el_i, .host_extension_enable_i, .el1_trap_to_el2_i, .walk_req_i,
	.walk_regime_i,
	.stage2_enable_i, .sysreg_ack_o, .sysreg_rdata_o, .sysreg_undef_o, .sysreg_trap_el2_o,
	.sysreg_trap_el3_o, .walk_ack_o, .page_hw_attribute_o);

// file: verif/page_walk_attr_control_test.sv
// testbench: register access, trap, alias and walk attribute checks
`timescale 1ns/1ps
module page_walk_attr_control_test;
	localparam logic [3:0] OK = 4'h8, UD = 4'hc, T2 = 4'ha, T3 = 4'h9, NO = 4'h0;
	localparam logic [2:0] E1 = 3'h0, HYP = 3'h4, AL = 3'h5, MON = 3'h6, B = 3'h0, S2 = 3'h1;
	logic clock_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic req = 1'h0, wr = 1'h0, hee = 1'h0, t2 = 1'h0, t3 = 1'h0, s2en = 1'h0;
	logic [2:0] op1 = 3'h0, op2 = 3'h0;
	logic [3:0] crm = 4'h7;
	logic [1:0] el = 2'h0;
	logic [63:0] wd = 64'h0;
	logic ack, undef, tr2, tr3, wreq, wack, up, sec;
	logic [1:0] rg, attr;
	logic [63:0] rd;
	int failures = 0, n_checks = 0;
	always #10 clock_i = ~clock_i;
	page_walk_attr_control DUT (.clock_i, .sys_rst_i, .sysreg_req_i(req), .sysreg_write_i(wr),
		.sysreg_op0_i(2'h3), .sysreg_op1_i(op1), .sysreg_crn_i(4'hf), .sysreg_crm_i(crm),
		.sysreg_op2_i(op2), .sysreg_wdata_i(wd), .cur_el_i(el), .host_extension_enable_i(hee),
		.el1_trap_to_el2_i(t2), .el1_trap_to_el3_i(t3), .walk_req_i(wreq), .walk_regime_i(rg),
		.walk_upper_base_i(up), .walk_secure_i(sec), .stage2_enable_i(s2en), .sysreg_ack_o(ack),
		.sysreg_rdata_o(rd), .sysreg_undef_o(undef), .sysreg_trap_el2_o(tr2),
		.sysreg_trap_el3_o(tr3), .walk_ack_o(wack), .page_hw_attribute_o(attr));
	walk_requester walker (.clock_i, .walk_ack_i(wack), .attr_i(attr), .walk_req_o(wreq),
		.regime_o(rg), .upper_o(up), .secure_o(sec));
	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
		n_checks++;
		if (got !== ex) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic acc(input logic w, input logic [2:0] o1, o2, input logic [1:0] e,
			input logic [63:0] d, input logic [3:0] st, input logic [63:0] ex);
		@(posedge clock_i);
		#1;
		req = 1'h1;
		wr = w;
		op1 = o1;
		op2 = o2;
		el = e;
		wd = d;
		@(posedge clock_i);
		#1;
		req = 1'h0;
		wd = ~d;
		chk("status", {60'h0, st}, {60'h0, ack, undef, tr2, tr3});
		if (!w) chk("rdata", ex, rd);
	endtask
	task automatic walk(input logic [1:0] r, input logic u, input logic s, input logic [1:0] ex);
		logic [1:0] at;
		walker.issue(r, u, s, at);
		chk("attr", {62'h0, ex}, {62'h0, at});
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clock_i);
		failures++;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge clock_i);
		#1;
		sys_rst_i = 1'h0;
		acc(0, HYP, B, 2'h3, '0, OK, '0);
		acc(0, MON, B, 2'h3, '0, OK, '0);
		acc(0, HYP, S2, 2'h3, '0, OK, '0);
		acc(0, E1, B, 2'h3, '0, OK, '0);
		walk(2'h2, 1, 0, 2'h0);
		acc(1, HYP, B, 2'h2, '1, OK, '0);
		acc(0, HYP, B, 2'h3, '0, OK, 64'h3333);
		acc(1, MON, B, 2'h3, '1, OK, '0);
		acc(0, MON, B, 2'h3, '0, OK, 64'h303);
		acc(1, HYP, S2, 2'h3, '1, OK, '0);
		acc(0, HYP, S2, 2'h2, '0, OK, 64'h303);
		acc(0, MON, B, 2'h2, '0, UD, '0);
		acc(1, HYP, B, 2'h1, '0, UD, '0);
		acc(0, HYP, S2, 2'h1, '0, UD, '0);
		acc(0, HYP, B, 2'h3, '0, OK, 64'h3333);
		acc(0, E1, B, 2'h0, '0, UD, '0);
		acc(1, AL, B, 2'h2, 64'h1111, UD, '0);
		hee = 1'h1;
		acc(1, AL, B, 2'h2, 64'h1111, OK, '0);
		acc(0, AL, B, 2'h1, '0, UD, '0);
		acc(0, E1, B, 2'h3, '0, OK, 64'h1111);
		acc(0, E1, B, 2'h2, '0, OK, 64'h3333);
		t2 = 1'h1;
		acc(0, E1, B, 2'h1, '0, T2, '0);
		t2 = 1'h0;
		t3 = 1'h1;
		acc(0, AL, B, 2'h2, '0, T3, '0);
		t3 = 1'h0;
		crm = 4'h6;
		acc(0, HYP, B, 2'h3, '0, NO, '0);
		crm = 4'h7;
		acc(1, HYP, B, 2'h2, 64'h3020, OK, '0);
		walk(2'h2, 1, 0, 2'h2);
		acc(1, HYP, B, 2'h2, 64'h3010, OK, '0);
		walk(2'h2, 1, 0, 2'h1);
		acc(1, HYP, B, 2'h2, 64'h0302, OK, '0);
		walk(2'h2, 0, 0, 2'h2);
		acc(1, HYP, B, 2'h2, 64'h0301, OK, '0);
		walk(2'h2, 0, 0, 2'h1);
		walk(2'h0, 1, 0, 2'h1);
		walk(2'h3, 0, 0, 2'h3);
		acc(1, MON, B, 2'h3, 64'h0302, OK, '0);
		walk(2'h3, 0, 0, 2'h2);
		walk(2'h1, 0, 0, 2'h0);
		s2en = 1'h1;
		walk(2'h1, 0, 0, 2'h3);
		walk(2'h1, 0, 1, 2'h0);
		sys_rst_i = 1'h1;
		@(posedge clock_i);
		#1;
		sys_rst_i = 1'h0;
		chk("attr_rst", '0, {62'h0, attr});
		acc(0, MON, B, 2'h3, '0, OK, '0);
		stop_test;
	end
endmodule

// file: verif/walk_requester.sv
// partner: page table walker that issues walks and collects attribute bits
`timescale 1ns/1ps
module walk_requester (
	input wire logic clock_i,
	input wire logic walk_ack_i,
	input wire logic [1:0] attr_i,
	output logic walk_req_o,
	output logic [1:0] regime_o,
	output logic upper_o,
	output logic secure_o
);
	initial begin
		walk_req_o = 1'h0;
		regime_o = 2'h0;
		upper_o = 1'h0;
		secure_o = 1'h0;
	end
	task automatic issue(input logic [1:0] rg, input logic up, input logic sec,
			output logic [1:0] at);
		int n;
		@(posedge clock_i);
		#1;
		walk_req_o = 1'h1;
		regime_o = rg;
		upper_o = up;
		secure_o = sec;
		@(posedge clock_i);
		#1;
		// qualifiers no longer valid: show inverted values
		walk_req_o = 1'h0;
		regime_o = ~rg;
		upper_o = ~up;
		secure_o = ~sec;
		n = 0;
		while (walk_ack_i !== 1'h1 && n < 4) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		at = (walk_ack_i === 1'h1) ? attr_i : 2'hx;
	endtask
endmodule
